// ===== core/multibuffered_serial_port.sv
// Multibuffered serial port with APB registers, word RAM and GPIO pin fallback.
module multibuffered_serial_port
    import serial_port_pkg::*;
(
    input  wire  logic                                ref_clk,
    input  wire  logic                                reset,
    input  wire  logic                                psel,
    input  wire  logic                                penable,
    input  wire  logic                                pwrite,
    input  wire  logic [serial_port_pkg::ADDR_W-1:0] paddr,
    input  wire  logic [31:0]                         pwdata,
    output logic       [31:0]                         prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire  logic [serial_port_pkg::PINS-1:0]   pinIn,
    output logic       [serial_port_pkg::PINS-1:0]   pinOut,
    output logic       [serial_port_pkg::PINS-1:0]   pinOe
);
    import serial_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0]       ctrl_q, ctrl_d;
    format_t          fmt_q [2];
    format_t          fmt_d [2];
    delay_t           dly_q, dly_d;
    group_t           grp_q, grp_d;
    logic [PINS-1:0]  pinFn_q, pinFn_d, gpDir_q, gpDir_d, gpOut_q, gpOut_d;
    mem_sel_t         memSel_q, memSel_d;
    logic [15:0]      rxBuf_q, rxBuf_d;
    logic             rxFull_q, rxFull_d, grpDone_q, grpDone_d;
    logic             active_q, active_d, fetchOn_q, fetchOn_d;
    logic [IDX_W-1:0] fetchIdx_q, fetchIdx_d;
    logic [31:0]      prdata_q, prdata_d;
    logic             pready_q, pready_d, pslverr_q, pslverr_d;
    logic             memWrTx, memWrCtrl, access;
    logic [PINS-1:0]  pinS1_q, pinS2_q;
    logic             clkS3_q;
    logic [15:0]      txMem [256];
    logic [15:0]      rxMem [256];
    logic [15:0]      ctrlMem [256];
    logic [15:0]      statMem [256];
    fifo_word_t       slot_q [FIFO_DEPTH];
    logic             wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [1:0]       count_q, count_d;
    logic             inValid, inReady, outValid, outReady;
    shift_state_t     st_q, st_d;
    fifo_word_t       cur_q, cur_d;
    format_t          fc_q, fc_d;
    logic [15:0]      sr_q, sr_d;
    logic             out_q, out_d, sclk_q, sclk_d, selN_q, selN_d;
    logic [8:0]       cnt_q, cnt_d, dcnt_q, dcnt_d;
    logic [4:0]       bits_q, bits_d, effLen;
    logic [8:0]       period, half;
    logic             master, slaveSel, inBit, lead, trail, wordDone, sclkRise, sclkFall;
    logic [15:0]      rxWord, fieldRd;
    word_stat_t       wordStat;
    logic [PINS-1:0]  funcOut, funcOe;

    assign master   = ctrl_q[CTRL_MASTER];
    assign slaveSel = ~pinS2_q[PIN_SEL];
    assign inBit    = master ? pinS2_q[PIN_SOMI] : pinS2_q[PIN_SIMO];
    assign access   = psel & penable & ~pready_q;
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin inputs pass two flip-flops; the third stage only serves clock edge detection.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pinS1_q <= '0;
            pinS2_q <= '0;
            clkS3_q <= 1'b0;
        end else begin
            pinS1_q <= pinIn;
            pinS2_q <= pinS1_q;
            clkS3_q <= pinS2_q[PIN_CLK];
        end
    end
    assign sclkRise = pinS2_q[PIN_CLK] & ~clkS3_q;
    assign sclkFall = ~pinS2_q[PIN_CLK] & clkS3_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Register file, APB slave and transfer group fetch pointer.
    always_comb begin
        ctrl_d = ctrl_q; fmt_d = fmt_q; dly_d = dly_q; grp_d = grp_q;
        pinFn_d = pinFn_q; gpDir_d = gpDir_q; gpOut_d = gpOut_q;
        memSel_d = memSel_q; rxBuf_d = rxBuf_q; rxFull_d = rxFull_q;
        grpDone_d = grpDone_q; active_d = active_q; fetchOn_d = fetchOn_q;
        fetchIdx_d = fetchIdx_q; prdata_d = prdata_q;
        pready_d = 1'b0; pslverr_d = 1'b0; memWrTx = 1'b0; memWrCtrl = 1'b0;
        unique case (memSel_q.field)
            FLD_TX:   fieldRd = txMem[memSel_q.idx];
            FLD_RX:   fieldRd = rxMem[memSel_q.idx];
            FLD_CTRL: fieldRd = ctrlMem[memSel_q.idx];
            FLD_STAT: fieldRd = statMem[memSel_q.idx];
        endcase
        if (access) begin
            pready_d = 1'b1;
            prdata_d = '0;
            case (paddr)
                OFF_CTRL: begin
                    prdata_d[1:0] = ctrl_q;
                    if (pwrite) ctrl_d = pwdata[1:0];
                end
                OFF_FMT0, OFF_FMT1: begin
                    prdata_d[$bits(format_t)-1:0] = fmt_q[paddr == OFF_FMT1];
                    if (pwrite) fmt_d[paddr == OFF_FMT1] = format_t'(pwdata[$bits(format_t)-1:0]);
                end
                OFF_DELAY: begin
                    prdata_d[15:0] = dly_q;
                    if (pwrite) dly_d = delay_t'(pwdata[15:0]);
                end
                OFF_GROUP: begin
                    prdata_d[15:0] = grp_q;
                    if (pwrite) begin
                        grp_d = group_t'(pwdata[15:0]);
                        if (pwdata[GROUP_GO] && !active_q) begin
                            active_d = 1'b1;
                            fetchOn_d = 1'b1;
                            fetchIdx_d = pwdata[IDX_W-1:0];
                        end
                    end
                end
                OFF_STATUS: begin
                    prdata_d[STAT_BUSY] = active_q;
                    prdata_d[STAT_DONE] = grpDone_q;
                    prdata_d[STAT_RXFULL] = rxFull_q;
                    if (pwrite && pwdata[STAT_DONE]) grpDone_d = 1'b0;
                end
                OFF_RXBUF: begin
                    prdata_d[15:0] = rxBuf_q;
                    if (!pwrite) rxFull_d = 1'b0;
                end
                OFF_PINFN: begin
                    prdata_d[PINS-1:0] = pinFn_q;
                    if (pwrite) pinFn_d = pwdata[PINS-1:0];
                end
                OFF_GPDIR: begin
                    prdata_d[PINS-1:0] = gpDir_q;
                    if (pwrite) gpDir_d = pwdata[PINS-1:0];
                end
                OFF_GPOUT: begin
                    prdata_d[PINS-1:0] = gpOut_q;
                    if (pwrite) gpOut_d = pwdata[PINS-1:0];
                end
                OFF_GPIN:  prdata_d[PINS-1:0] = pinS2_q;
                OFF_MEMADDR: begin
                    prdata_d[$bits(mem_sel_t)-1:0] = memSel_q;
                    if (pwrite) memSel_d = mem_sel_t'(pwdata[$bits(mem_sel_t)-1:0]);
                end
                OFF_MEMDATA: begin
                    prdata_d[15:0] = fieldRd;
                    memWrTx = pwrite && memSel_q.field == FLD_TX;
                    memWrCtrl = pwrite && memSel_q.field == FLD_CTRL;
                end
                default: pslverr_d = 1'b1;
            endcase
        end
        // Fetch walks the group's consecutive entries into the buffer.
        if (fetchOn_q && inReady) begin
            fetchIdx_d = fetchIdx_q + 1'b1;
            if (fetchIdx_q == grp_q.last) fetchOn_d = 1'b0;
        end
        if (active_q && !fetchOn_q && !outValid && st_q == ST_IDLE) begin
            active_d = 1'b0;
            grpDone_d = 1'b1;
        end
        if (!ctrl_q[CTRL_EN]) begin
            fetchOn_d = 1'b0;
        end
        // Hardware updates come last so a completion beats a same-cycle clear.
        if (wordDone) begin
            rxBuf_d = rxWord;
            rxFull_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_q <= '0; fmt_q <= '{default: '0}; dly_q <= '0; grp_q <= '0;
            pinFn_q <= '0; gpDir_q <= '0; gpOut_q <= '0; memSel_q <= '0;
            rxBuf_q <= '0; rxFull_q <= 1'b0; grpDone_q <= 1'b0;
            active_q <= 1'b0; fetchOn_q <= 1'b0; fetchIdx_q <= '0;
            prdata_q <= '0; pready_q <= 1'b0; pslverr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d; fmt_q <= fmt_d; dly_q <= dly_d; grp_q <= grp_d;
            pinFn_q <= pinFn_d; gpDir_q <= gpDir_d; gpOut_q <= gpOut_d;
            memSel_q <= memSel_d; rxBuf_q <= rxBuf_d; rxFull_q <= rxFull_d;
            grpDone_q <= grpDone_d; active_q <= active_d; fetchOn_q <= fetchOn_d;
            fetchIdx_q <= fetchIdx_d; prdata_q <= prdata_d;
            pready_q <= pready_d; pslverr_q <= pslverr_d;
        end
    end

    // Word memory: software owns transmit and control, the shifter owns the rest.
    always_ff @(posedge ref_clk) begin
        if (memWrTx) txMem[memSel_q.idx] <= pwdata[15:0];
        if (memWrCtrl) ctrlMem[memSel_q.idx] <= pwdata[15:0];
        if (wordDone) begin
            rxMem[cur_q.idx] <= rxWord;
            statMem[cur_q.idx] <= wordStat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Two-entry buffer between the memory fetch and the shifter.
    assign inValid  = fetchOn_q;
    assign inReady  = count_q != 2'(FIFO_DEPTH);
    assign outValid = count_q != 2'h0;

    always_comb begin
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (inValid && inReady) wrPtr_d = ~wrPtr_q;
        if (outValid && outReady) rdPtr_d = ~rdPtr_q;
        count_d = count_q + 2'(inValid && inReady) - 2'(outValid && outReady);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wrPtr_q <= 1'b0; rdPtr_q <= 1'b0; count_q <= '0;
            slot_q <= '{default: '0};
        end else begin
            wrPtr_q <= wrPtr_d; rdPtr_q <= rdPtr_d; count_q <= count_d;
            if (inValid && inReady)
                slot_q[wrPtr_q] <= '{fetchIdx_q, txMem[fetchIdx_q], ctrlMem[fetchIdx_q]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shifter: per-word format, select timing, clock generation and shifting.
    always_comb begin
        period = fc_q.prescale == '0 ? PER_ZERO : 9'(fc_q.prescale) + 9'h001;
        half = period >> 1;
        effLen = fc_q.len < MIN_LEN ? MIN_LEN : (fc_q.len > MAX_LEN ? MAX_LEN : fc_q.len);
        if (master) begin
            lead = st_q == ST_SETUP && dcnt_q == '0;
            trail = st_q == ST_SHIFT && cnt_q == half - 9'h001;
        end else begin
            lead = st_q == ST_SHIFT && slaveSel && (fc_q.cpol ? sclkFall : sclkRise);
            trail = st_q == ST_SHIFT && slaveSel && (fc_q.cpol ? sclkRise : sclkFall);
        end
        rxWord = sr_q & ~(ONES << effLen);
        wordStat = '0;
        wordStat.done = 1'b1;
        wordStat.overrun = rxFull_q;
        st_d = st_q; cur_d = cur_q; fc_d = fc_q; sr_d = sr_q; out_d = out_q;
        sclk_d = sclk_q; selN_d = selN_q; cnt_d = cnt_q; dcnt_d = dcnt_q; bits_d = bits_q;
        outReady = 1'b0;
        wordDone = 1'b0;
        unique case (st_q)
            ST_IDLE: begin
                selN_d = 1'b1;
                sclk_d = fc_q.cpol;
                if (outValid && ctrl_q[CTRL_EN] && (master || slaveSel)) begin
                    outReady = 1'b1;
                    cur_d = slot_q[rdPtr_q];
                    fc_d = fmt_q[slot_q[rdPtr_q].ctrl.fmtSel];
                    sclk_d = fc_d.cpol;
                    sr_d = slot_q[rdPtr_q].tx << (MAX_LEN - (fc_d.len < MIN_LEN ? MIN_LEN
                           : (fc_d.len > MAX_LEN ? MAX_LEN : fc_d.len)));
                    if (!fc_d.cpha) out_d = sr_d[15];
                    bits_d = '0;
                    cnt_d = '0;
                    selN_d = ~master;
                    dcnt_d = 9'(dly_q.c2t) + SETUP_ADD - 9'h001;
                    st_d = master ? ST_SETUP : ST_SHIFT;
                end
            end
            ST_SETUP: begin
                if (dcnt_q != '0) dcnt_d = dcnt_q - 9'h001;
                else st_d = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (master) cnt_d = cnt_q == period - 9'h001 ? '0 : cnt_q + 9'h001;
            end
            ST_HOLD: begin
                if (dcnt_q != '0) dcnt_d = dcnt_q - 9'h001;
                else begin
                    selN_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
        endcase
        // Master leading edges after the first come from the period counter.
        if (master && st_q == ST_SHIFT && cnt_q == period - 9'h001 && bits_q != effLen)
            lead = 1'b1;
        // Bits launch on the leading edge and are sampled on the trailing edge, so the
        // line stays put for half a period on either side of the sampling edge.
        if (lead) begin
            if (master) sclk_d = ~fc_q.cpol;
            out_d = sr_q[15];
        end
        if (trail) begin
            if (master) sclk_d = fc_q.cpol;
            sr_d = {sr_q[14:0], inBit};
            bits_d = bits_q + 5'h01;
        end
        if (st_q == ST_SHIFT && !master && !slaveSel) st_d = ST_IDLE;
        if (st_q == ST_SHIFT && ((master && cnt_q == period - 9'h001 && bits_q == effLen)
            || (!master && bits_d == effLen && bits_q != effLen))) begin
            wordDone = 1'b1;
            if (!master) st_d = ST_IDLE;
            else if (cur_q.ctrl.hold && outValid) begin
                outReady = 1'b1;
                cur_d = slot_q[rdPtr_q];
                fc_d = fmt_q[slot_q[rdPtr_q].ctrl.fmtSel];
                sr_d = slot_q[rdPtr_q].tx << (MAX_LEN - (fc_d.len < MIN_LEN ? MIN_LEN
                       : (fc_d.len > MAX_LEN ? MAX_LEN : fc_d.len)));
                if (!fc_d.cpha) out_d = sr_d[15];
                bits_d = '0;
                cnt_d = '0;
                dcnt_d = 9'(dly_q.c2t) + SETUP_ADD_HOLD - 9'h001;
                st_d = ST_SETUP;
            end else begin
                dcnt_d = 9'(dly_q.t2c) + HOLD_ADD - 9'h001;
                st_d = ST_HOLD;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= ST_IDLE; cur_q <= '0; fc_q <= '0; sr_q <= '0;
            out_q <= 1'b0; sclk_q <= 1'b0; selN_q <= 1'b1;
            cnt_q <= '0; dcnt_q <= '0; bits_q <= '0;
        end else begin
            st_q <= st_d; cur_q <= cur_d; fc_q <= fc_d; sr_q <= sr_d;
            out_q <= out_d; sclk_q <= sclk_d; selN_q <= selN_d;
            cnt_q <= cnt_d; dcnt_q <= dcnt_d; bits_q <= bits_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin multiplexing between the port function and software I/O.
    assign funcOut[PIN_CLK]  = sclk_q;
    assign funcOut[PIN_SIMO] = out_q;
    assign funcOut[PIN_SOMI] = out_q;
    assign funcOut[PIN_SEL]  = selN_q;
    assign funcOe[PIN_CLK]   = master;
    assign funcOe[PIN_SIMO]  = master;
    assign funcOe[PIN_SOMI]  = ~master & slaveSel & ctrl_q[CTRL_EN];
    assign funcOe[PIN_SEL]   = master;

    for (genvar i = 0; i < PINS; i++) begin : g_pin
        assign pinOut[i] = pinFn_q[i] ? funcOut[i] : gpOut_q[i];
        assign pinOe[i]  = pinFn_q[i] ? funcOe[i] : gpDir_q[i];
    end
endmodule

// ===== core/serial_port_pkg.sv
// Constants and types shared by the multibuffered serial port.
package serial_port_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int IDX_W  = 8;
    localparam int PINS   = 4;
    localparam int FIFO_DEPTH = 2;
    localparam int PIN_CLK  = 0;
    localparam int PIN_SIMO = 1;
    localparam int PIN_SOMI = 2;
    localparam int PIN_SEL  = 3;
    localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_FMT0    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_FMT1    = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DELAY   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_GROUP   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_RXBUF   = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_PINFN   = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_GPDIR   = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_GPOUT   = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_GPIN    = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_MEMADDR = 8'h2C;
    localparam logic [ADDR_W-1:0] OFF_MEMDATA = 8'h30;
    localparam int CTRL_EN     = 0;
    localparam int CTRL_MASTER = 1;
    localparam int GROUP_GO    = 16;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_DONE   = 1;
    localparam int STAT_RXFULL = 2;
    localparam logic [1:0] FLD_TX   = 2'h0;
    localparam logic [1:0] FLD_RX   = 2'h1;
    localparam logic [1:0] FLD_CTRL = 2'h2;
    localparam logic [1:0] FLD_STAT = 2'h3;
    localparam logic [4:0] MIN_LEN = 5'h02;
    localparam logic [4:0] MAX_LEN = 5'h10;
    localparam logic [8:0] PER_ZERO = 9'h002;
    localparam logic [8:0] SETUP_ADD = 9'h002;
    localparam logic [8:0] SETUP_ADD_HOLD = 9'h003;
    localparam logic [8:0] HOLD_ADD = 9'h001;
    localparam logic [DATA_W-1:0] ONES = 16'hFFFF;
    typedef struct packed {
        logic       cpol;
        logic       cpha;
        logic [7:0] prescale;
        logic [2:0] rsvd;
        logic [4:0] len;
    } format_t;
    typedef struct packed { logic [7:0] t2c; logic [7:0] c2t; } delay_t;
    typedef struct packed { logic [7:0] last; logic [7:0] first; } group_t;
    typedef struct packed { logic [13:0] rsvd; logic hold; logic fmtSel; } word_ctrl_t;
    typedef struct packed { logic [13:0] rsvd; logic overrun; logic done; } word_stat_t;
    typedef struct packed { logic [1:0] field; logic [IDX_W-1:0] idx; } mem_sel_t;
    typedef struct packed {
        logic [IDX_W-1:0]  idx;
        logic [DATA_W-1:0] tx;
        word_ctrl_t        ctrl;
    } fifo_word_t;
    typedef enum logic [1:0] { ST_IDLE, ST_SETUP, ST_SHIFT, ST_HOLD } shift_state_t;
endpackage

// ===== verification/serial_peer_model.sv
// Behavioural serial peripheral that answers the master and records link timing.
module serial_peer_model (
    input  wire logic        ref_clk,
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        selN,
    input  wire logic [15:0] replyWord,
    output logic             somi,
    output logic [15:0]      gotWord,
    output logic [4:0]       bitCount,
    output logic [8:0]       leadCycles,
    output logic [8:0]       period
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        clkQ = 1'b0;
    logic        selQ = 1'b1;
    logic        lastQ = 1'b0;
    logic [15:0] shQ = 16'h0000;
    logic [8:0]  cntQ = 9'h000;
    logic [8:0]  riseQ = 9'h000;
    // Deselected, the line shows the inverse of the last bit so no stale value passes.
    assign somi = selN ? ~lastQ : shQ[15];
    always @(posedge ref_clk) begin
        clkQ <= sclk;
        selQ <= selN;
        cntQ <= cntQ + 9'h001;
        if (!selN) lastQ <= shQ[15];
        if (selQ && !selN) begin
            shQ <= replyWord;
            cntQ <= 9'h001;
            riseQ <= 9'h000;
            bitCount <= 5'h00;
        end else if (!selN && !clkQ && sclk) begin
            riseQ <= cntQ;
            if (riseQ == 9'h000) leadCycles <= cntQ;
            else period <= cntQ - riseQ;
        end else if (!selN && clkQ && !sclk) begin
            gotWord <= {gotWord[14:0], mosi};
            shQ <= {shQ[14:0], 1'b0};
            bitCount <= bitCount + 5'h01;
        end
    end
endmodule

// ===== verification/serial_port_props.sv
// Checker for bus handshake and master link timing of the serial port.
module serial_port_props
    import serial_port_pkg::*;
(
    input wire logic                                ref_clk,
    input wire logic                                reset,
    input wire logic                                psel,
    input wire logic                                penable,
    input wire logic                                pwrite,
    input wire logic [serial_port_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                         pwdata,
    input wire logic [31:0]                         prdata,
    input wire logic                                pready,
    input wire logic                                pslverr,
    input wire logic [serial_port_pkg::PINS-1:0]   pinIn,
    input wire logic [serial_port_pkg::PINS-1:0]   pinOut,
    input wire logic [serial_port_pkg::PINS-1:0]   pinOe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    ready_after_access_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle into the access phase");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_needs_req_a: assert property (pready |-> psel && penable)
        else $error("ready without an access phase");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag outside an answer");
    error_reads_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    clock_in_frame_a: assert property (
        pinOe[PIN_CLK] && pinOe[PIN_SEL] && $changed(pinOut[PIN_CLK]) |-> !pinOut[PIN_SEL])
        else $error("serial clock moved while deselected");
    data_around_sample_a: assert property (
        $fell(pinOut[PIN_CLK]) && !pinOut[PIN_SEL]
        |-> pinOut[PIN_SIMO] == $past(pinOut[PIN_SIMO], 2) ##1 $stable(pinOut[PIN_SIMO]))
        else $error("output bit not steady around its sampling edge");
    select_lead_a: assert property ($fell(pinOut[PIN_SEL]) |-> $stable(pinOut[PIN_CLK]) [*2])
        else $error("clock edge too soon after select");
endmodule
bind multibuffered_serial_port serial_port_props props (.ref_clk(ref_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe));

// ===== verification/tb.sv
// Self-checking bench: reads are queued with expectations and judged by a monitor.
module tb;
    import serial_port_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed { logic err; logic [31:0] mask; logic [31:0] data; } note_t;
    logic            ref_clk, reset, psel, penable, pwrite, pready, pslverr, somi;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic [3:0]      pinIn, pinOut, pinOe, gpioIn;
    logic [15:0]     reply, gotWord, tx0, tx1;
    logic [4:0]      bitCount;
    logic [8:0]      leadCycles, period;
    int              n_mismatch = 0;
    int              tests_run = 0;
    note_t           notes[$];
    note_t           nt;
    assign pinIn = (pinOe & pinOut) | (~pinOe & {gpioIn[3], somi, gpioIn[1:0]});
    multibuffered_serial_port dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
    serial_peer_model peer (.ref_clk(ref_clk), .sclk(pinIn[0]), .mosi(pinIn[1]),
        .selN(pinIn[3]), .replyWord(reply), .somi(somi), .gotWord(gotWord),
        .bitCount(bitCount), .leadCycles(leadCycles), .period(period));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                       input logic err = 1'b0);
        notes.push_back('{err, m, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    always @(posedge ref_clk) begin
        if (pready === 1'b1 && pwrite === 1'b0 && notes.size() > 0) begin
            nt = notes.pop_front();
            check({pslverr, prdata & nt.mask}, {nt.err, nt.data & nt.mask}, "read");
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rd} = '0;
        reset = 1'b1;
        gpioIn = 4'h0;
        reply = 16'h0000;
        void'($urandom(8));
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rdx(OFF_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
        rdx(8'h40, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        apb(1'b1, OFF_GPDIR, 32'h0000_000F);
        apb(1'b1, OFF_GPOUT, 32'h0000_000A);
        repeat (2) @(posedge ref_clk);
        check({25'h0, pinOe, pinOut}, {25'h0, 8'hFA}, "gpio out");
        apb(1'b1, OFF_GPDIR, 32'h0000_0000);
        gpioIn <= 4'($urandom());
        repeat (4) @(posedge ref_clk);
        rdx(OFF_GPIN, {28'h0, gpioIn}, 32'h0000_000B);
        tx0 = 16'($urandom());
        tx1 = 16'($urandom());
        reply = 16'($urandom());
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, OFF_MEMADDR, {22'h0, FLD_TX, 8'hFE + 8'(k)});
            apb(1'b1, OFF_MEMDATA, {16'h0, (k == 0) ? tx0 : tx1});
            apb(1'b1, OFF_MEMADDR, {22'h0, FLD_CTRL, 8'hFE + 8'(k)});
            apb(1'b1, OFF_MEMDATA, 32'(k));
        end
        rdx(OFF_MEMDATA, 32'h0000_0001, 32'h0000_FFFF);
        apb(1'b1, OFF_FMT0, 32'h0000_0708);
        apb(1'b1, OFF_FMT1, 32'h0000_090C);
        apb(1'b1, OFF_DELAY, 32'h0000_0103);
        apb(1'b1, OFF_PINFN, 32'h0000_000F);
        apb(1'b1, OFF_CTRL, 32'h0000_0003);
        apb(1'b1, OFF_GROUP, 32'h0001_FFFE);
        rd = '0;
        for (int p = 0; p < 300 && rd[STAT_DONE] !== 1'b1; p++) apb(1'b0, OFF_STATUS, 32'h0);
        check({32'h0, rd[STAT_DONE]}, 33'h0_0000_0001, "group done");
        check({24'h0, leadCycles}, 33'h0_0000_0005, "lead");
        check({24'h0, period}, 33'h0_0000_000A, "period");
        check({28'h0, bitCount}, 33'h0_0000_000C, "bits");
        check({21'h0, gotWord[11:0]}, {21'h0, tx1[11:0]}, "shifted out");
        rdx(OFF_RXBUF, {16'h0, reply >> 4}, 32'h0000_0FFF);
        apb(1'b1, OFF_MEMADDR, {22'h0, FLD_RX, 8'hFE});
        apb(1'b1, OFF_MEMDATA, 32'h0000_0000);
        rdx(OFF_MEMDATA, {16'h0, reply >> 8}, 32'h0000_00FF);
        apb(1'b1, OFF_MEMADDR, {22'h0, FLD_STAT, 8'hFF});
        rdx(OFF_MEMDATA, 32'h0000_0001, 32'h0000_0001);
        end_sim();
    end
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_mismatch++;
        end_sim();
    end
endmodule
